/* dcc_pkg.sv */
package dcc_pkg;

   // ****************************************
   // register map
   // ****************************************
   localparam int NCMP = 2;
   localparam logic [NCMP-1:0][7:0] ADDR_CTL = {8'h9A, 8'h9B};
   localparam logic [NCMP-1:0][7:0] ADDR_MUX = {8'h9E, 8'h9F};
   localparam logic [NCMP-1:0][7:0] ADDR_MODE = {8'h9C, 8'h9D};
   localparam logic [7:0] ADDR_IRQ_STS = 8'hA0;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'hA1;
   localparam logic [7:0] ADDR_RST_SRC = 8'hA2;

   // ****************************************
   // field positions
   // ****************************************
   localparam int BIT_EN = 7;
   localparam int BIT_OUT = 6;
   localparam int BIT_RISE = 5;
   localparam int BIT_FALL = 4;
   localparam int BIT_HYP_LO = 2;
   localparam int BIT_HYN_LO = 0;
   localparam int BIT_NEG_LO = 4;
   localparam int BIT_POS_LO = 0;
   localparam int BIT_RIE = 5;
   localparam int BIT_FIE = 4;
   localparam int BIT_MD_LO = 0;
   localparam int BIT_RST_EN = 0;
   localparam int STS_RISE = 0;
   localparam int STS_FALL = 1;

   // ****************************************
   // reset values and codes
   // ****************************************
   localparam logic [7:0] RST_CTL = 8'h00;
   localparam logic [7:0] RST_MUX = 8'h00;
   localparam logic [1:0] RST_MD = 2'h2;
   localparam logic [1:0] HYST_OFF = 2'h0;
   localparam logic [1:0] HYST_20MV = 2'h3;
   localparam logic [1:0] MD_FASTEST = 2'h0;
   localparam logic [1:0] MD_LOWEST_POWER = 2'h3;

   // ****************************************
   // types
   // ****************************************
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } dcc_bus_s;

   typedef struct packed {
      logic en;
      logic out;
      logic rise;
      logic fall;
      logic [1:0] hyp;
      logic [1:0] hyn;
   } dcc_ctl_s;

   typedef struct packed {
      logic [2:0] neg;
      logic [2:0] pos;
   } dcc_mux_s;

   typedef struct packed {
      logic rie;
      logic fie;
      logic [1:0] md;
   } dcc_mode_s;

   typedef struct packed {
      logic en;
      logic [1:0] hyp;
      logic [1:0] hyn;
      logic [2:0] pos;
      logic [2:0] neg;
      logic [1:0] md;
   } dcc_ana_s;

   typedef struct packed {
      logic meta;
      logic sync;
   } dcc_sync_s;

   typedef struct packed {
      logic prev;
      logic prev_en;
   } dcc_edge_s;

endpackage

/* dcc_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module dcc_sync
   import dcc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic d,
   output logic q
);

   // ****************************************
   // two-flop synchroniser
   // ****************************************
   dcc_sync_s st_ff;
   dcc_sync_s nxt_st;

   always_comb begin
      nxt_st.meta = d;
      nxt_st.sync = st_ff.meta;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign q = st_ff.sync;

endmodule
`default_nettype wire

/* dcc_edge.sv */
`timescale 1ns/1ns
`default_nettype none
module dcc_edge
   import dcc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic sample,
   input wire logic en,
   output logic level,
   output logic rise,
   output logic fall
);

   // ****************************************
   // edges between consecutive samples
   // ****************************************
   dcc_edge_s st_ff;
   dcc_edge_s nxt_st;

   // a disabled comparator reads low; enabling or disabling is no edge
   assign level = sample & en;
   assign rise = en & st_ff.prev_en & level & ~st_ff.prev;
   assign fall = en & st_ff.prev_en & ~level & st_ff.prev;

   always_comb begin
      nxt_st.prev = level;
      nxt_st.prev_en = en;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

endmodule
`default_nettype wire

/* dcc_top.sv */
// Notes on behaviour
// - two identical comparators; only zero resets
// - raw async output plus clocked latched output
// - disabled comparator drives its pin low
// - falling output edge sets fall flag, bit4
// - rising output edge sets rise flag, bit5
// - flags stay set until software writes zero
// - bit6 reads present comparator output
// - bit7 enables or disables comparator
// - rising and falling edges raise interrupts
// - control bits3-0 hold both hysteresis pairs
// - negative hysteresis code 11 means 20 mV
// - separate register selects positive, negative inputs
// - mode register selects response time
// - comparator zero selectable as reset source
// - mode bits1-0, mode 0 fastest, 3 lowest
// - mode bits5,4 gate rise and fall interrupts
//
// Local design decision: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
module dcc_top
   import dcc_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic RST,
   input wire dcc_bus_s REG_REQ,
   output logic [7:0] RD_DATA,
   input wire logic [NCMP-1:0] CMP_RAW,
   output dcc_ana_s [NCMP-1:0] ANA_CFG,
   output logic [NCMP-1:0] RAW_OUT,
   output logic [NCMP-1:0] LATCHED_OUT,
   output logic IRQ,
   output logic CMP0_RST_REQ
);

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      dcc_ctl_s [NCMP-1:0] ctl;
      dcc_mux_s [NCMP-1:0] mux;
      dcc_mode_s [NCMP-1:0] mode;
      logic [2*NCMP-1:0] sts;
      logic [2*NCMP-1:0] mask;
      logic rst_en;
      logic [7:0] rdata;
      logic [NCMP-1:0] latched;
      logic irq;
      logic rst_req;
   } dcc_top_s;

   dcc_top_s st_ff;
   dcc_top_s nxt_st;
   logic [NCMP-1:0] cmp_sync;
   logic [NCMP-1:0] level;
   logic [NCMP-1:0] rise_p;
   logic [NCMP-1:0] fall_p;

   // ****************************************
   // per-comparator sampling
   // ****************************************
   // both channels share one datapath; only input sets and reset use differ
   for (genvar n = 0; n < NCMP; n++) begin : g_cmp
      dcc_sync u_sync (
         .clk(SYS_CLK),
         .rst(RST),
         .d(CMP_RAW[n]),
         .q(cmp_sync[n])
      );
      dcc_edge u_edge (
         .clk(SYS_CLK),
         .rst(RST),
         .sample(cmp_sync[n]),
         .en(st_ff.ctl[n].en),
         .level(level[n]),
         .rise(rise_p[n]),
         .fall(fall_p[n])
      );
      // raw path bypasses every flop so it keeps working with no clock
      assign RAW_OUT[n] = CMP_RAW[n] & st_ff.ctl[n].en;
      assign ANA_CFG[n].en = st_ff.ctl[n].en;
      assign ANA_CFG[n].hyp = st_ff.ctl[n].hyp;
      assign ANA_CFG[n].hyn = st_ff.ctl[n].hyn;
      assign ANA_CFG[n].pos = st_ff.mux[n].pos;
      assign ANA_CFG[n].neg = st_ff.mux[n].neg;
      assign ANA_CFG[n].md = st_ff.mode[n].md;
   end

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      logic [2*NCMP-1:0] sts_set;
      logic [7:0] wd;
      logic wr;
      nxt_st = st_ff;
      sts_set = '0;
      wd = REG_REQ.wdata;
      wr = REG_REQ.wr;
      for (int n = 0; n < NCMP; n++) begin
         if (wr && REG_REQ.addr == ADDR_CTL[n]) begin
            nxt_st.ctl[n].en = wd[BIT_EN];
            nxt_st.ctl[n].rise = wd[BIT_RISE];
            nxt_st.ctl[n].fall = wd[BIT_FALL];
            nxt_st.ctl[n].hyp = wd[BIT_HYP_LO +: 2];
            nxt_st.ctl[n].hyn = wd[BIT_HYN_LO +: 2];
         end
         if (wr && REG_REQ.addr == ADDR_MUX[n]) begin
            nxt_st.mux[n].neg = wd[BIT_NEG_LO +: 3];
            nxt_st.mux[n].pos = wd[BIT_POS_LO +: 3];
         end
         if (wr && REG_REQ.addr == ADDR_MODE[n]) begin
            nxt_st.mode[n].rie = wd[BIT_RIE];
            nxt_st.mode[n].fie = wd[BIT_FIE];
            nxt_st.mode[n].md = wd[BIT_MD_LO +: 2];
         end
         // an edge in the clearing cycle wins over the write
         if (rise_p[n]) begin
            nxt_st.ctl[n].rise = 1'b1;
         end
         if (fall_p[n]) begin
            nxt_st.ctl[n].fall = 1'b1;
         end
         nxt_st.ctl[n].out = level[n];
         nxt_st.latched[n] = level[n];
         sts_set[2*n+STS_RISE] = rise_p[n] & st_ff.mode[n].rie;
         sts_set[2*n+STS_FALL] = fall_p[n] & st_ff.mode[n].fie;
      end
      if (wr && REG_REQ.addr == ADDR_IRQ_STS) begin
         nxt_st.sts = st_ff.sts & ~wd[2*NCMP-1:0];
      end
      nxt_st.sts = nxt_st.sts | sts_set;
      if (wr && REG_REQ.addr == ADDR_IRQ_MASK) begin
         nxt_st.mask = wd[2*NCMP-1:0];
      end
      if (wr && REG_REQ.addr == ADDR_RST_SRC) begin
         nxt_st.rst_en = wd[BIT_RST_EN];
      end
      nxt_st.irq = |(nxt_st.sts & nxt_st.mask);
      // output low means the negative input is above the positive one
      nxt_st.rst_req = st_ff.rst_en & st_ff.ctl[0].en & ~level[0];
      nxt_st.rdata = 8'h00;
      if (REG_REQ.rd) begin
         for (int n = 0; n < NCMP; n++) begin
            if (REG_REQ.addr == ADDR_CTL[n]) begin
               nxt_st.rdata = st_ff.ctl[n];
            end
            if (REG_REQ.addr == ADDR_MUX[n]) begin
               nxt_st.rdata = {1'b0, st_ff.mux[n].neg, 1'b0, st_ff.mux[n].pos};
            end
            if (REG_REQ.addr == ADDR_MODE[n]) begin
               nxt_st.rdata = {2'h0, st_ff.mode[n].rie, st_ff.mode[n].fie,
                               2'h0, st_ff.mode[n].md};
            end
         end
         case (REG_REQ.addr)
            ADDR_IRQ_STS: begin
               nxt_st.rdata = {4'h0, st_ff.sts};
            end
            ADDR_IRQ_MASK: begin
               nxt_st.rdata = {4'h0, st_ff.mask};
            end
            ADDR_RST_SRC: begin
               nxt_st.rdata = {7'h00, st_ff.rst_en};
            end
            default: begin
            end
         endcase
      end
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         st_ff <= '0;
         st_ff.ctl <= {NCMP{RST_CTL}};
         st_ff.mux <= {NCMP{RST_MUX[5:0]}};
         st_ff.mode[0].md <= RST_MD;
         st_ff.mode[1].md <= RST_MD;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign RD_DATA = st_ff.rdata;
   assign LATCHED_OUT = st_ff.latched;
   assign IRQ = st_ff.irq;
   assign CMP0_RST_REQ = st_ff.rst_req;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (RST);

   logic wr_ctl0;
   assign wr_ctl0 = REG_REQ.wr && REG_REQ.addr == ADDR_CTL[0];

   a_rise_sets_flag: assert property (rise_p[0] |=> st_ff.ctl[0].rise)
      else $error("rising edge did not set rise flag");
   a_fall_sets_flag: assert property (fall_p[1] |=> st_ff.ctl[1].fall)
      else $error("falling edge did not set fall flag");
   a_flag_holds: assert property (st_ff.ctl[0].rise && !wr_ctl0 |=> st_ff.ctl[0].rise)
      else $error("rise flag cleared without a write");
   a_disabled_pin_low: assert property (!st_ff.ctl[0].en |-> !RAW_OUT[0] ##1 !LATCHED_OUT[0])
      else $error("disabled comparator output not low");
   a_out_bit_read: assert property (REG_REQ.rd && REG_REQ.addr == ADDR_CTL[0]
      |=> RD_DATA[BIT_OUT] == $past(st_ff.ctl[0].out))
      else $error("output state bit reads wrong");
   a_enable_write: assert property (wr_ctl0 |=> ##1 ANA_CFG[0].en == $past(REG_REQ.wdata[BIT_EN], 2))
      else $error("enable bit not taken from write");
   a_hyst_write: assert property (wr_ctl0 |=> ANA_CFG[0].hyn == $past(REG_REQ.wdata[1:0]))
      else $error("negative hysteresis not taken from write");
   a_mode_write: assert property (REG_REQ.wr && REG_REQ.addr == ADDR_MODE[1]
      |=> ANA_CFG[1].md == $past(REG_REQ.wdata[1:0]))
      else $error("response mode not taken from write");
   a_irq_on_edge: assert property (rise_p[0] && st_ff.mode[0].rie && st_ff.mask[STS_RISE]
      && !REG_REQ.wr |=> IRQ && st_ff.sts[STS_RISE])
      else $error("enabled rising edge gave no interrupt");
   a_irq_gated: assert property (fall_p[0] && !st_ff.mode[0].fie && !st_ff.sts[STS_FALL]
      |=> !st_ff.sts[STS_FALL])
      else $error("disabled falling edge set status");
   a_reset_source: assert property (st_ff.rst_en && st_ff.ctl[0].en && !level[0]
      |=> CMP0_RST_REQ)
      else $error("comparator zero reset request missing");

   c_rise_irq: cover property (rise_p[0] ##1 IRQ);
   c_fall_flag: cover property (fall_p[1] ##1 st_ff.ctl[1].fall);
   c_reset_req: cover property (CMP0_RST_REQ);
   c_hyst_max: cover property (ANA_CFG[0].hyn == HYST_20MV);

endmodule
`default_nettype wire

/* dcc_ana_model.sv */
`timescale 1ns/1ns
`default_nettype none
module dcc_ana_model
   import dcc_pkg::*;
(
   input wire logic clk,
   input wire dcc_ana_s [NCMP-1:0] cfg,
   input wire logic [NCMP-1:0] target,
   output logic [NCMP-1:0] cmp_raw
);
   // ****************************************
   // comparator cores, alike but for inputs
   // ****************************************
   logic [NCMP-1:0][3:0] pipe_ff;
   always_ff @(posedge clk) begin
      for (int i = 0; i < NCMP; i++) begin
         pipe_ff[i] <= {pipe_ff[i][2:0], target[i]};
      end
   end
   // slower modes answer later, so latency is not assumed fixed
   always_comb begin
      for (int i = 0; i < NCMP; i++) begin
         if (!cfg[i].en) begin
            cmp_raw[i] = 1'b0;
         end else if (cfg[i].md == MD_FASTEST) begin
            cmp_raw[i] = target[i];
         end else begin
            cmp_raw[i] = pipe_ff[i][cfg[i].md - 2'h1];
         end
      end
   end
endmodule
`default_nettype wire

/* dcc_top_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module dcc_top_tb
   import dcc_pkg::*;
;
   typedef struct packed {
      logic [7:0] a;
      logic [7:0] d;
      logic [7:0] r;
      logic [7:0] e;
   } dcc_row_s;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   dcc_bus_s reg_req = '0;
   logic [7:0] rd_data;
   logic [NCMP-1:0] target = '0;
   logic [NCMP-1:0] cmp_raw;
   dcc_ana_s [NCMP-1:0] ana_cfg;
   logic [NCMP-1:0] raw_out;
   logic [NCMP-1:0] latched_out;
   logic irq;
   logic cmp0_rst_req;
   int failures = 0;
   int checks = 0;
   int cycles = 0;
   dcc_row_s rows [9] = '{
      '{ADDR_CTL[0], 8'h4F, 8'h00, 8'h0F},
      '{ADDR_CTL[1], 8'h0B, 8'h00, 8'h0B},
      '{ADDR_MUX[0], 8'hFF, 8'h00, 8'h77},
      '{ADDR_MUX[1], 8'h80, 8'h00, 8'h00},
      '{ADDR_MODE[0], 8'hFF, 8'h02, 8'h33},
      '{ADDR_MODE[1], 8'hCF, 8'h02, 8'h03},
      '{ADDR_IRQ_MASK, 8'hFF, 8'h00, 8'h0F},
      '{ADDR_RST_SRC, 8'hFF, 8'h00, 8'h01},
      '{8'h55, 8'hFF, 8'h00, 8'h00}
   };

   dcc_top dcc_top_i (
      .SYS_CLK(sys_clk),
      .RST(rst),
      .REG_REQ(reg_req),
      .RD_DATA(rd_data),
      .CMP_RAW(cmp_raw),
      .ANA_CFG(ana_cfg),
      .RAW_OUT(raw_out),
      .LATCHED_OUT(latched_out),
      .IRQ(irq),
      .CMP0_RST_REQ(cmp0_rst_req)
   );
   dcc_ana_model dcc_ana_model_i (
      .clk(sys_clk),
      .cfg(ana_cfg),
      .target(target),
      .cmp_raw(cmp_raw)
   );

   // ****************************************
   // clock, watchdog and bus tasks
   // ****************************************
   always #5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         summarize();
      end
   end
   task automatic summarize();
      if (failures == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      chk8({7'h00, got}, {7'h00, exp});
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk);
      reg_req.wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk);
      reg_req.rd <= 1'b0;
      #1;
      chk8(rd_data, exp);
   endtask
   // bounded wait, the model may be in a slow mode
   task automatic wait_out(input int i, input logic v);
      for (int n = 0; n < 20 && latched_out[i] !== v; n++) begin
         @(posedge sys_clk);
         #1;
      end
      chk1(latched_out[i], v);
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      foreach (rows[k]) begin
         rd(rows[k].a, rows[k].r);
         wr(rows[k].a, rows[k].d);
         rd(rows[k].a, rows[k].e);
      end
      chk8({6'h00, ana_cfg[0].hyn}, {6'h00, HYST_20MV});
      chk8({5'h00, ana_cfg[0].pos}, 8'h07);
      chk8({5'h00, ana_cfg[0].neg}, 8'h07);
      chk8({6'h00, ana_cfg[0].hyp}, {6'h00, HYST_20MV});
      wr(ADDR_CTL[0], 8'h80);
      wr(ADDR_MODE[0], 8'h30);
      repeat (5) @(posedge sys_clk);
      #1;
      chk1(cmp0_rst_req, 1'b1);
      target[0] <= 1'b1;
      wait_out(0, 1'b1);
      chk1(raw_out[0], 1'b1);
      chk1(irq, 1'b1);
      chk1(cmp0_rst_req, 1'b0);
      rd(ADDR_CTL[0], 8'hE0);
      rd(ADDR_IRQ_STS, 8'h01);
      wr(ADDR_IRQ_STS, 8'h01);
      rd(ADDR_IRQ_STS, 8'h00);
      chk1(irq, 1'b0);
      target[0] <= 1'b0;
      wait_out(0, 1'b0);
      rd(ADDR_CTL[0], 8'hB0);
      rd(ADDR_IRQ_STS, 8'h02);
      wr(ADDR_IRQ_MASK, 8'h00);
      @(posedge sys_clk);
      #1;
      chk1(irq, 1'b0);
      wr(ADDR_CTL[0], 8'h80);
      rd(ADDR_CTL[0], 8'h80);
      wr(ADDR_CTL[0], 8'h00);
      target[0] <= 1'b1;
      repeat (6) @(posedge sys_clk);
      #1;
      chk1(raw_out[0], 1'b0);
      chk1(latched_out[0], 1'b0);
      rd(ADDR_IRQ_STS, 8'h02);
      wr(ADDR_CTL[1], 8'h80);
      wr(ADDR_MODE[1], 8'h33);
      wr(ADDR_IRQ_MASK, 8'h0F);
      target[1] <= 1'b1;
      wait_out(1, 1'b1);
      chk8({6'h00, ana_cfg[1].md}, {6'h00, MD_LOWEST_POWER});
      rd(ADDR_IRQ_STS, 8'h06);
      chk1(irq, 1'b1);
      rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      #1;
      chk1(irq, 1'b0);
      chk8(rd_data, 8'h00);
      chk8({6'h00, ana_cfg[0].md}, {6'h00, RST_MD});
      rst <= 1'b0;
      rd(ADDR_CTL[1], 8'h00);
      summarize();
   end
endmodule
`default_nettype wire
